//--- src/host_port_defines.svh
// constants for the parallel host port: direct ports, indirect numbers, bits, timing
// assumes one 40 MHz clock; included by bare name
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// direct ports selected by the two address lines
`define PORT_ADDR        2'h0
`define PORT_DATA        2'h1
`define PORT_FIFO        2'h2
`define PORT_STATUS      2'h3

// indirect register numbers
`define IND_SLOW_LAST    8'h8F
`define IND_PRAM_WRITE   8'h7E
`define IND_CPU_RELEASE  8'h7F
`define IND_PRAM_READ    8'h8E
`define IND_IRQ_ENABLE   8'hC1
`define IND_IRQ_CONFIG   8'hC2

// bit positions
`define BIT_CYCLE_DONE   0
`define BIT_PUSH_PULL    0

// reset values and increments
`define BYTE_ZERO        8'h00
`define PRAM_PTR_ZERO    8'h00
`define PRAM_PTR_STEP    8'h01
`define WAIT_ZERO        12'h000
`define WAIT_STEP        12'h001

// program memory size
`define PRAM_DEPTH       256

// longest internal latency, and its cycle count at the clock rate
`define CLK_PERIOD_NS    25
`define SLOW_LATENCY_US  64
`define SLOW_LATENCY_CYC 12'((`SLOW_LATENCY_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- src/host_port_pkg.sv
// types shared by the parallel host port
// assumes host_port_defines.svh holds the numeric constants
package host_port_pkg;

    // host cycle sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_WAIT,
        ST_DONE
    } host_state_t;

endpackage

//--- src/host_port_indirect_access.sv
// parallel host port: direct ports, indirect access, program memory load and readback
// assumes host pins are synchronous to clk; internal register side answers with intDone
//
// Functional notes
// - strobe low opens cycle; device pulls ready low, later releases it
// - interrupt is open-drain active low; C2 selects push-pull active high
// - indirect numbers 00-8F may take 64 us; tracked as pending
// - slow read waits after address write; slow write waits after data write
// - enable bit in C1 raises interrupt when slow access completes
// - numbers 90-CF complete at once and never raise cycle-complete
// - read at port 2 returns next sliced VBI byte in one access
// - port 3 reads or writes the status/interrupt flags
// - status bit clears only on a written one; zero leaves it
// - data writes while pointer holds 7E go to next program byte
// - program load holds processor in reset at location zero afterwards
// - any write to 7F releases processor reset; value ignored
// - selecting 8E fetches next program byte and holds processor reset
// - readback completion signalled once fetched byte sits in data port
// - processor stays in reset during readback until 7F write
`timescale 1ns/1ps
`include "host_port_defines.svh"

module host_port_indirect_access (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // host parallel port pins
    input  wire logic       csN,
    input  wire logic       strobeN,
    input  wire logic       readNotWrite,
    input  wire logic [1:0] hostAddr,
    input  wire logic [7:0] hostDataIn,
    output logic      [7:0] hostDataOut,
    output logic            hostDataOeN,
    output logic            readyOut,
    output logic            readyOeN,
    // interrupt pin
    output logic            irqOut,
    output logic            irqOeN,
    // internal register side
    output logic            host_irq_out,
    output logic            intWrite,
    output logic      [7:0] intAddr,
    output logic      [7:0] intWData,
    input  wire logic [7:0] intRData,
    input  wire logic       intDone,
    // sliced VBI data, show-ahead
    input  wire logic [7:0] fifoData,
    output logic            fifoPop,
    // other interrupt sources, one-cycle events, bit 0 unused
    input  wire logic [7:0] srcEvent,
    // microprocessor held in reset at location zero
    output logic            cpuHold
);

    host_port_pkg::host_state_t state;

    logic [1:0] cycPort;
    logic       cycRead;
    logic [7:0] cycData;
    logic [7:0] addrPtr;
    logic [7:0] dataReg;
    logic [7:0] irqEnable;
    logic [7:0] irqConfig;
    logic [7:0] status;
    logic [7:0] clearMask;
    logic       doneSet;
    logic       pending;
    logic       pendRead;
    logic [11:0] waitCount;
    logic [7:0] ramPtr;
    logic [7:0] pram [`PRAM_DEPTH];
    logic       ramWrite;
    logic       slowSel;
    logic       localSel;
    logic       pendFinish;

    // decode of the currently selected indirect number
    assign slowSel    = (addrPtr <= `IND_SLOW_LAST);
    assign localSel   = (addrPtr == `IND_PRAM_WRITE) || (addrPtr == `IND_CPU_RELEASE) ||
                        (addrPtr == `IND_PRAM_READ) || (addrPtr == `IND_IRQ_ENABLE) ||
                        (addrPtr == `IND_IRQ_CONFIG);
    // timeout ends a stuck access so the host never hangs past the worst latency
    assign pendFinish = pending && (intDone || (waitCount >= `SLOW_LATENCY_CYC));
    assign ramWrite   = (state == host_port_pkg::ST_EXEC) && !cycRead && (cycPort == `PORT_DATA) &&
                        (addrPtr == `IND_PRAM_WRITE);

    // host cycle sequencer and indirect access control
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state       <= host_port_pkg::ST_IDLE;
            cycPort     <= `PORT_ADDR;
            cycRead     <= 1'b0;
            cycData     <= `BYTE_ZERO;
            addrPtr     <= `BYTE_ZERO;
            dataReg     <= `BYTE_ZERO;
            irqEnable   <= `BYTE_ZERO;
            irqConfig   <= `BYTE_ZERO;
            hostDataOut <= `BYTE_ZERO;
            hostDataOeN <= 1'b1;
            readyOeN    <= 1'b1;
            host_irq_out      <= 1'b0;
            intWrite    <= 1'b0;
            intAddr     <= `BYTE_ZERO;
            intWData    <= `BYTE_ZERO;
            pending     <= 1'b0;
            pendRead    <= 1'b0;
            waitCount   <= `WAIT_ZERO;
            fifoPop     <= 1'b0;
            clearMask   <= `BYTE_ZERO;
            doneSet     <= 1'b0;
            ramPtr      <= `PRAM_PTR_ZERO;
            cpuHold     <= 1'b0;
        end else begin
            host_irq_out    <= 1'b0;
            fifoPop   <= 1'b0;
            clearMask <= `BYTE_ZERO;
            doneSet   <= 1'b0;
            // slow access finishing in the background
            if (pending) begin
                waitCount <= waitCount + `WAIT_STEP;
            end
            if (pendFinish) begin
                pending <= 1'b0;
                doneSet <= 1'b1;
                if (pendRead) begin
                    dataReg <= intRData;
                end
            end
            unique case (state)
                host_port_pkg::ST_IDLE: begin
                    if (!csN && !strobeN) begin
                        cycPort  <= hostAddr;
                        cycRead  <= readNotWrite;
                        cycData  <= hostDataIn;
                        readyOeN <= 1'b0;
                        state    <= host_port_pkg::ST_EXEC;
                    end
                end
                host_port_pkg::ST_EXEC: begin
                    // ready stays low; indirect ports wait out a pending access
                    if (pending && (cycPort == `PORT_ADDR || cycPort == `PORT_DATA)) begin
                        state <= host_port_pkg::ST_EXEC;
                    end else begin
                        state <= host_port_pkg::ST_DONE;
                        unique case (cycPort)
                            `PORT_ADDR: begin
                                if (cycRead) begin
                                    hostDataOut <= addrPtr;
                                end else begin
                                    addrPtr <= cycData;
                                    if (cycData == `IND_PRAM_READ) begin
                                        dataReg <= pram[ramPtr];
                                        ramPtr  <= ramPtr + `PRAM_PTR_STEP;
                                        cpuHold <= 1'b1;
                                        doneSet <= 1'b1;
                                    end else if (cycData <= `IND_SLOW_LAST &&
                                                 cycData != `IND_PRAM_WRITE &&
                                                 cycData != `IND_CPU_RELEASE) begin
                                        host_irq_out    <= 1'b1;
                                        intWrite  <= 1'b0;
                                        intAddr   <= cycData;
                                        pending   <= 1'b1;
                                        pendRead  <= 1'b1;
                                        waitCount <= `WAIT_ZERO;
                                    end
                                end
                            end
                            `PORT_DATA: begin
                                if (addrPtr == `IND_IRQ_ENABLE) begin
                                    if (cycRead) hostDataOut <= irqEnable;
                                    else irqEnable <= cycData;
                                end else if (addrPtr == `IND_IRQ_CONFIG) begin
                                    if (cycRead) hostDataOut <= irqConfig;
                                    else irqConfig <= cycData;
                                end else if (slowSel && cycRead) begin
                                    hostDataOut <= dataReg;
                                end else if (!cycRead && addrPtr == `IND_PRAM_WRITE) begin
                                    ramPtr  <= ramPtr + `PRAM_PTR_STEP;
                                    cpuHold <= 1'b1;
                                    doneSet <= 1'b1;
                                end else if (!cycRead && addrPtr == `IND_CPU_RELEASE) begin
                                    cpuHold <= 1'b0;
                                    ramPtr  <= `PRAM_PTR_ZERO;
                                    doneSet <= 1'b1;
                                end else if (!cycRead && slowSel && !localSel) begin
                                    host_irq_out    <= 1'b1;
                                    intWrite  <= 1'b1;
                                    intAddr   <= addrPtr;
                                    intWData  <= cycData;
                                    pending   <= 1'b1;
                                    pendRead  <= 1'b0;
                                    waitCount <= `WAIT_ZERO;
                                end else begin
                                    // fast range: finish inside this host cycle, no flag
                                    host_irq_out    <= 1'b1;
                                    intWrite  <= !cycRead;
                                    intAddr   <= addrPtr;
                                    intWData  <= cycData;
                                    waitCount <= `WAIT_ZERO;
                                    state     <= host_port_pkg::ST_WAIT;
                                end
                            end
                            `PORT_FIFO: begin
                                if (cycRead) begin
                                    hostDataOut <= fifoData;
                                    fifoPop     <= 1'b1;
                                end
                            end
                            `PORT_STATUS: begin
                                if (cycRead) hostDataOut <= status;
                                else clearMask <= cycData;
                            end
                        endcase
                    end
                end
                host_port_pkg::ST_WAIT: begin
                    waitCount <= waitCount + `WAIT_STEP;
                    if (intDone || waitCount >= `SLOW_LATENCY_CYC) begin
                        hostDataOut <= intRData;
                        state       <= host_port_pkg::ST_DONE;
                    end
                end
                host_port_pkg::ST_DONE: begin
                    // data is driven in the same cycle that ready is released
                    if (cycRead) begin
                        hostDataOeN <= 1'b0;
                    end
                    readyOeN <= 1'b1;
                    if (strobeN) begin
                        hostDataOeN <= 1'b1;
                        state       <= host_port_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ready only ever pulled low; the external pull-up releases it
    always_ff @(posedge clk) begin
        readyOut <= 1'b0;
    end

    // program memory in flip-flops, loaded one byte per data write
    always_ff @(posedge clk) begin
        if (ramWrite) begin
            pram[ramPtr] <= cycData;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status <= `BYTE_ZERO;
        end else begin
            status <= (status & ~clearMask) | srcEvent |
                      (8'(doneSet) << `BIT_CYCLE_DONE);
        end
    end

    // interrupt pin: open drain active low unless push-pull chosen
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqOut <= 1'b0;
            irqOeN <= 1'b1;
        end else if (irqConfig[`BIT_PUSH_PULL]) begin
            irqOut <= |(status & irqEnable);
            irqOeN <= 1'b0;
        end else begin
            irqOut <= 1'b0;
            irqOeN <= ~|(status & irqEnable);
        end
    end

endmodule // host_port_indirect_access

//--- verif/host_port_checker.sv
// checker for the host port: strobe handshake, direct ports, internal request spacing
// assumes bind to host_port_indirect_access; host holds strobe until ready is released
`timescale 1ns/1ps
module host_port_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // host pins
    input wire logic       csN,
    input wire logic       strobeN,
    input wire logic       readNotWrite,
    input wire logic [1:0] hostAddr,
    input wire logic       readyOeN,
    input wire logic       hostDataOeN,
    input wire logic       irqOut,
    input wire logic       irqOeN,
    // internal side
    input wire logic       host_irq_out,
    input wire logic       intDone,
    input wire logic       fifoPop,
    input wire logic       cpuHold
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic pend;

    // internal access open from request to answer
    always_ff @(posedge clk) begin
        if (!resetn || intDone) begin
            pend <= 1'b0;
        end else if (host_irq_out) begin
            pend <= 1'b1;
        end
    end

    chk_ready_pull: assert property ($fell(strobeN) && !csN |=> !readyOeN)
        else $error("ready not pulled low after strobe");
    chk_ready_stand: assert property (readyOeN && !strobeN && !csN && !$fell(strobeN) |=> readyOeN)
        else $error("ready pulled low again within one cycle");
    chk_data_ready: assert property ($fell(hostDataOeN) |-> readyOeN && readNotWrite)
        else $error("data bus driven outside a read completion");
    chk_status_quick: assert property ($fell(strobeN) && !csN && hostAddr == 2'h3 |=> !readyOeN ##2 readyOeN)
        else $error("status access not completed in two cycles");
    chk_fifo_pop: assert property ($fell(strobeN) && !csN && readNotWrite && hostAddr == 2'h2 |-> ##[1:4] fifoPop)
        else $error("fifo read did not pop");
    chk_req_pulse: assert property (host_irq_out || fifoPop |=> !host_irq_out && !fifoPop)
        else $error("request or pop longer than one cycle");
    chk_irq_idle: assert property (irqOeN |-> !irqOut)
        else $error("interrupt output high while released");
    chk_one_pending: assert property (pend |-> !host_irq_out)
        else $error("second internal access while one pending");
    chk_port_blocked: assert property (pend && $fell(strobeN) && !csN && !hostAddr[1] |=> !readyOeN [*4])
        else $error("indirect port not held busy while pending");
    chk_hold_cause: assert property ($changed(cpuHold) |-> !readyOeN || !$past(readyOeN))
        else $error("processor hold changed outside a host cycle");

    cover property (pend ##1 intDone);
    cover property (fifoPop);
    cover property ($rose(cpuHold));
endmodule // host_port_checker

bind host_port_indirect_access host_port_checker chk (.clk(clk), .resetn(resetn), .csN(csN), .strobeN(strobeN),
    .readNotWrite(readNotWrite), .hostAddr(hostAddr), .readyOeN(readyOeN), .hostDataOeN(hostDataOeN),
    .irqOut(irqOut), .irqOeN(irqOeN), .host_irq_out(host_irq_out), .intDone(intDone), .fifoPop(fifoPop), .cpuHold(cpuHold));

//--- verif/int_reg_model.sv
// model of the internal register side and the sliced data fifo head
// assumes one request at a time; slow numbers answer after 40 cycles, the rest after 2
`timescale 1ns/1ps
module int_reg_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // internal register bus
    input wire logic       host_irq_out,
    input wire logic       intWrite,
    input wire logic [7:0] intAddr,
    input wire logic [7:0] intWData,
    output logic     [7:0] intRData,
    output logic           intDone,
    // fifo head
    input wire logic       fifoPop,
    output logic     [7:0] fifoData
);
    logic [7:0] mem [256];
    logic [7:0] cnt;
    logic [7:0] rdAddr;
    logic       busy;

    // answer after a latency; read data toggles when not valid so a stale value never passes
    always_ff @(posedge clk) begin
        intDone <= 1'b0;
        intRData <= ~intRData;
        if (!resetn) begin
            busy <= 1'b0;
            intRData <= 8'h00;
        end else if (host_irq_out) begin
            busy <= 1'b1;
            rdAddr <= intAddr;
            cnt <= (intAddr <= 8'h8F) ? 8'h28 : 8'h02;
            if (intWrite) begin
                mem[intAddr] <= intWData;
            end
        end else if (busy && cnt == 8'h01) begin
            busy <= 1'b0;
            intDone <= 1'b1;
            intRData <= mem[rdAddr];
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end

    // fifo head counts up on each pop
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fifoData <= 8'hA0;
        end else if (fifoPop) begin
            fifoData <= fifoData + 8'h01;
        end
    end
endmodule // int_reg_model

//--- verif/tb_top.sv
// self-checking bench for the host port: direct ports, indirect access, program memory
// assumes int_reg_model on the internal side; host cycles driven on falling edges
`timescale 1ns/1ps
module tb_top;
    logic       clk, resetn, csN, strobeN, readNotWrite, hostDataOeN, readyOut, readyOeN;
    logic       irqOut, irqOeN, host_irq_out, intWrite, intDone, fifoPop, cpuHold;
    logic [1:0] hostAddr;
    logic [7:0] hostDataIn, hostDataOut, intAddr, intWData, intRData, fifoData, srcEvent, q;
    int         nMismatch, checked;

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    host_port_indirect_access DUT (.clk(clk), .resetn(resetn), .csN(csN), .strobeN(strobeN),
        .readNotWrite(readNotWrite), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOeN(hostDataOeN), .readyOut(readyOut), .readyOeN(readyOeN), .irqOut(irqOut), .irqOeN(irqOeN),
        .host_irq_out(host_irq_out), .intWrite(intWrite), .intAddr(intAddr), .intWData(intWData), .intRData(intRData),
        .intDone(intDone), .fifoData(fifoData), .fifoPop(fifoPop), .srcEvent(srcEvent), .cpuHold(cpuHold));
    int_reg_model model (.clk(clk), .resetn(resetn), .host_irq_out(host_irq_out), .intWrite(intWrite), .intAddr(intAddr),
        .intWData(intWData), .intRData(intRData), .intDone(intDone), .fifoPop(fifoPop), .fifoData(fifoData));

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one host cycle; strobe held past the edge that samples ready released
    task automatic cyc(input logic [1:0] a, input logic r, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        {csN, strobeN, readNotWrite, hostAddr, hostDataIn} = {2'b00, r, a, d};
        while (readyOeN !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        while (readyOeN !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        q = hostDataOut;
        {csN, strobeN} = 2'b11;
        @(negedge clk);
        if (n >= 3000) begin
            nMismatch++;
            $display("[ERR] host cycle ready expected released seen stuck");
        end
    endtask

    // poll cycle-complete through the status port, optionally clear it
    task automatic waitdone(input logic clr);
        int n;
        n = 0;
        q = 8'h00;
        while (q[0] !== 1'b1 && n < 200) begin
            cyc(2'h3, 1'b1, 8'h00);
            n++;
        end
        cmp("cycle done", 8'h01, q & 8'h01);
        if (clr) begin
            cyc(2'h3, 1'b0, 8'h01);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatched %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard; the sequence needs a few hundred cycles
    initial begin
        repeat (40000) @(posedge clk);
        nMismatch++;
        complete_run();
    end

    initial begin
        {resetn, csN, strobeN, readNotWrite, hostAddr, hostDataIn, srcEvent} = {3'b011, 1'b0, 2'h0, 16'h0000};
        nMismatch = 0;
        checked = 0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        cmp("idle pins", 8'h0F, {3'h0, readyOut, readyOeN, hostDataOeN, irqOeN, ~cpuHold});
        // a slow pointer write prefetches and flags; clear that before the slow write
        cyc(2'h0, 1'b0, 8'h10);
        waitdone(1'b1);
        cyc(2'h1, 1'b0, 8'h5A);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("flag pending", 8'h00, q);
        cyc(2'h1, 1'b1, 8'h00);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("flag after wait", 8'h01, q);
        cyc(2'h3, 1'b0, 8'h00);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("flag kept", 8'h01, q);
        cyc(2'h3, 1'b0, 8'h01);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("flag cleared", 8'h00, q);
        // slow read: wait falls after the pointer write
        cyc(2'h0, 1'b0, 8'h10);
        waitdone(1'b1);
        cyc(2'h1, 1'b1, 8'h00);
        cmp("slow read", 8'h5A, q);
        cyc(2'h0, 1'b1, 8'h00);
        cmp("pointer", 8'h10, q);
        // enable completion interrupt, fast access leaves no flag
        cyc(2'h0, 1'b0, 8'hC1);
        cyc(2'h1, 1'b0, 8'h01);
        cyc(2'h1, 1'b1, 8'h00);
        cmp("irq enable", 8'h01, q);
        cyc(2'h0, 1'b0, 8'h95);
        cyc(2'h1, 1'b0, 8'h33);
        cyc(2'h1, 1'b1, 8'h00);
        cmp("fast read", 8'h33, q);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("fast no flag", 8'h00, q);
        cmp("irq quiet", 8'h01, {7'h00, irqOeN});
        cyc(2'h0, 1'b0, 8'h20);
        waitdone(1'b1);
        cyc(2'h1, 1'b0, 8'h77);
        waitdone(1'b0);
        cmp("irq open drain", 8'h00, {6'h00, irqOeN, irqOut});
        cyc(2'h0, 1'b0, 8'hC2);
        cyc(2'h1, 1'b0, 8'h01);
        cmp("irq push pull", 8'h01, {6'h00, irqOeN, irqOut});
        cyc(2'h3, 1'b0, 8'h01);
        cmp("irq cleared", 8'h00, {6'h00, irqOeN, irqOut});
        // other source event into the status port
        @(negedge clk);
        srcEvent = 8'h04;
        @(negedge clk);
        srcEvent = 8'h00;
        cyc(2'h3, 1'b1, 8'h00);
        cmp("event flag", 8'h04, q);
        cyc(2'h3, 1'b0, 8'h04);
        cyc(2'h3, 1'b1, 8'h00);
        cmp("event cleared", 8'h00, q);
        for (int i = 0; i < 2; i++) begin
            cyc(2'h2, 1'b1, 8'h00);
            cmp("fifo byte", 8'hA0 + 8'(i), q);
        end
        // program memory load, release, readback, release
        cyc(2'h0, 1'b0, 8'h7E);
        for (int i = 0; i < 2; i++) begin
            cyc(2'h1, 1'b0, 8'h11 * 8'(i + 1));
            waitdone(1'b1);
        end
        cmp("cpu held", 8'h01, {7'h00, cpuHold});
        cyc(2'h0, 1'b0, 8'h7F);
        cyc(2'h1, 1'b0, 8'hA5);
        waitdone(1'b1);
        cmp("cpu released", 8'h00, {7'h00, cpuHold});
        for (int i = 0; i < 2; i++) begin
            cyc(2'h0, 1'b0, 8'h8E);
            waitdone(1'b1);
            cmp("cpu held in read", 8'h01, {7'h00, cpuHold});
            cyc(2'h1, 1'b1, 8'h00);
            cmp("program byte", 8'h11 * 8'(i + 1), q);
        end
        cyc(2'h0, 1'b0, 8'h7F);
        cyc(2'h1, 1'b0, 8'h00);
        waitdone(1'b1);
        cmp("cpu run again", 8'h00, {7'h00, cpuHold});
        complete_run();
    end
endmodule // tb_top
